// ===== hdl/clk_sel_pkg.sv
package clk_sel_pkg;

    localparam int REG_W = 8;

    // bit positions of the control registers
    localparam int MCM_SRC_SEL_BIT = 2;
    localparam int MCM_CPU_SEL_BIT = 0;
    localparam int PCC_XTAL_FORCE_BIT = 6;
    localparam int PCC_SUB_SEL_BIT = 4;
    localparam int OPM_MAIN_EXT_BIT = 7;
    localparam int OPM_MAIN_PIN_BIT = 6;
    localparam int OPM_SUB_EXT_BIT = 5;
    localparam int OPM_SUB_PIN_BIT = 4;
    localparam int OPM_RANGE_HI_BIT = 0;
    localparam int MOC_HALT_BIT = 7;
    localparam int IOM_FAST_HALT_BIT = 0;
    localparam int IOM_SLOW_HALT_BIT = 1;
    localparam int IOM_FAST_RUN_BIT = 7;

    // writable bits of each register, reserved bits stay zero
    localparam logic [REG_W-1:0] MCM_MASK = 8'h05;
    localparam logic [REG_W-1:0] PCC_MASK = 8'h50;
    localparam logic [REG_W-1:0] OPM_MASK = 8'hf1;
    localparam logic [REG_W-1:0] MOC_MASK = 8'h80;
    localparam logic [REG_W-1:0] IOM_MASK = 8'h03;

    // reset values
    localparam logic [REG_W-1:0] MCM_RST = 8'h00;
    localparam logic [REG_W-1:0] PCC_RST = 8'h00;
    localparam logic [REG_W-1:0] OPM_RST = 8'h00;
    localparam logic [REG_W-1:0] MOC_RST = 8'h80;
    localparam logic [REG_W-1:0] IOM_RST = 8'h00;

    // reset processing time after the supply passes the upper threshold
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_PROC_TIME_NS = 20000;
    localparam int POR_PROC_CYCLES =
        (POR_PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic we;
        logic [REG_W-1:0] data;
    } reg_wr_type;

    typedef enum logic [1:0] {
        SRC_HS,
        SRC_X1,
        SRC_EXT,
        SRC_SUB
    } src_type;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN_OLD,
        SW_WAIT_NEW
    } sw_state_type;

    typedef enum logic [1:0] {
        POR_CAPTURE,
        POR_WAIT_SUPPLY,
        POR_COUNT,
        POR_RUN
    } por_state_type;

endpackage

// ===== hdl/cpu_peripheral_clock_select.sv
// Contract
// - both domains on internal fast oscillator
// - cpu fast oscillator, peripherals on main
// - cpu and peripherals on main clock
// - cpu on subsystem, peripherals per selects
// - source select bit2, cpu select bit0
// - crystal force bit6, subsystem select bit4
// - op mode bits 7,6,5,4,0
// - main oscillator halt at bit7
// - default cpu clock is fast oscillator
// - dual mode waits supply, then 20us
// - range and source select change once
// - clearing slow halt restarts slow oscillator
// - flags report current cpu clock
// - setting fast halt stops fast oscillator
`timescale 1ns/100ps
`default_nettype none
module cpu_peripheral_clock_select
    import clk_sel_pkg::*;
#(
    parameter int POR_CYCLES = POR_PROC_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic POR_DUAL_MODE,
    input wire logic SUPPLY_ABOVE_HI,
    input wire logic HS_OSC_CLK,
    input wire logic X1_CLK,
    input wire logic EXT_MAIN_CLK,
    input wire logic SUB_CLK,
    input wire reg_wr_type MAIN_CLOCK_MODE_WR,
    input wire reg_wr_type PROC_CLOCK_CTRL_WR,
    input wire reg_wr_type CLOCK_OP_MODE_WR,
    input wire reg_wr_type MAIN_OSC_CTRL_WR,
    input wire reg_wr_type INTERNAL_OSC_MODE_WR,
    output logic [REG_W-1:0] MAIN_CLOCK_MODE_Q,
    output logic [REG_W-1:0] PROC_CLOCK_CTRL_Q,
    output logic [REG_W-1:0] CLOCK_OP_MODE_Q,
    output logic [REG_W-1:0] MAIN_OSC_CTRL_Q,
    output logic [REG_W-1:0] INTERNAL_OSC_MODE_Q,
    output logic CPU_ON_SUB_FLAG,
    output logic CPU_ON_MAIN_FLAG,
    output logic CPU_RUN,
    output logic CPU_CLK_OUT,
    output logic PERI_CLK_OUT,
    output logic HS_OSC_EN,
    output logic LS_OSC_EN,
    output logic MAIN_OSC_EN,
    output logic MAIN_XTAL_MODE,
    output logic SUB_OSC_EN,
    output logic SUB_XTAL_MODE
);

    localparam int CNT_W = $clog2(POR_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POR_CYCLES - 1);
    localparam int NCH = 2;

    logic [REG_W-1:0] mcm_r;
    logic [REG_W-1:0] pcc_r;
    logic [REG_W-1:0] opm_r;
    logic [REG_W-1:0] moc_r;
    logic [REG_W-1:0] iom_r;
    logic src_lock_r;
    logic range_lock_r;
    logic [3:0] clk_meta_r;
    logic [3:0] clk_sync_r;
    logic sup_meta_r;
    logic sup_sync_r;
    logic dual_r;
    por_state_type por_r;
    logic [CNT_W-1:0] cnt_r;
    logic run_r;
    src_type want [NCH];
    src_type tgt_r [NCH];
    src_type cur_r [NCH];
    sw_state_type sw_r [NCH];
    logic gate_r [NCH];
    logic out_r [NCH];

    // main system clock source from the external-input select
    function automatic src_type main_src(input logic ext_sel);
        return ext_sel ? SRC_EXT : SRC_X1;
    endfunction

    // synchronise clock levels and the supply comparator
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            clk_meta_r <= 4'h0;
            clk_sync_r <= 4'h0;
            sup_meta_r <= 1'b0;
            sup_sync_r <= 1'b0;
        end else begin
            clk_meta_r <= {SUB_CLK, EXT_MAIN_CLK, X1_CLK, HS_OSC_CLK};
            clk_sync_r <= clk_meta_r;
            sup_meta_r <= SUPPLY_ABOVE_HI;
            sup_sync_r <= sup_meta_r;
        end
    end

    // main clock mode register, source select writable once
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mcm_r <= MCM_RST;
            src_lock_r <= 1'b0;
        end else if (MAIN_CLOCK_MODE_WR.we) begin
            mcm_r[MCM_CPU_SEL_BIT] <= MAIN_CLOCK_MODE_WR.data[MCM_CPU_SEL_BIT];
            if (!src_lock_r) begin
                mcm_r[MCM_SRC_SEL_BIT] <=
                    MAIN_CLOCK_MODE_WR.data[MCM_SRC_SEL_BIT];
                src_lock_r <= MAIN_CLOCK_MODE_WR.data[MCM_SRC_SEL_BIT]
                    != mcm_r[MCM_SRC_SEL_BIT];
            end
        end
    end

    // processor clock control register
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pcc_r <= PCC_RST;
        end else if (PROC_CLOCK_CTRL_WR.we) begin
            pcc_r <= PROC_CLOCK_CTRL_WR.data & PCC_MASK;
        end
    end

    // clock operation mode register, range bit writable once
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            opm_r <= OPM_RST;
            range_lock_r <= 1'b0;
        end else if (CLOCK_OP_MODE_WR.we) begin
            opm_r[7:4] <= CLOCK_OP_MODE_WR.data[7:4];
            if (!range_lock_r) begin
                opm_r[OPM_RANGE_HI_BIT] <=
                    CLOCK_OP_MODE_WR.data[OPM_RANGE_HI_BIT];
                range_lock_r <= CLOCK_OP_MODE_WR.data[OPM_RANGE_HI_BIT]
                    != opm_r[OPM_RANGE_HI_BIT];
            end
        end
    end

    // main oscillator control and internal oscillator mode registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            moc_r <= MOC_RST;
            iom_r <= IOM_RST;
        end else begin
            if (MAIN_OSC_CTRL_WR.we) begin
                moc_r <= MAIN_OSC_CTRL_WR.data & MOC_MASK;
            end
            if (INTERNAL_OSC_MODE_WR.we) begin
                iom_r <= INTERNAL_OSC_MODE_WR.data & IOM_MASK;
            end
        end
    end

    // reset processing: strap caught after release, then supply wait in dual mode
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            por_r <= POR_CAPTURE;
            dual_r <= 1'b0;
            cnt_r <= '0;
            run_r <= 1'b0;
        end else begin
            unique case (por_r)
                POR_CAPTURE: begin
                    dual_r <= POR_DUAL_MODE;
                    por_r <= POR_DUAL_MODE ? POR_WAIT_SUPPLY : POR_RUN;
                    run_r <= !POR_DUAL_MODE;
                end
                POR_WAIT_SUPPLY: begin
                    if (sup_sync_r) begin
                        por_r <= POR_COUNT;
                    end
                end
                POR_COUNT: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_LAST) begin
                        por_r <= POR_RUN;
                        run_r <= 1'b1;
                    end
                end
                POR_RUN: begin
                    run_r <= 1'b1;
                end
            endcase
        end
    end

    // requested sources for cpu (0) and peripherals (1)
    always_comb begin
        if (pcc_r[PCC_SUB_SEL_BIT]) begin
            want[0] = SRC_SUB;
        end else if (mcm_r[MCM_SRC_SEL_BIT] && mcm_r[MCM_CPU_SEL_BIT]) begin
            want[0] = main_src(opm_r[OPM_MAIN_EXT_BIT]);
        end else begin
            want[0] = SRC_HS;
        end
        if (mcm_r[MCM_SRC_SEL_BIT]) begin
            want[1] = main_src(opm_r[OPM_MAIN_EXT_BIT]);
        end else begin
            want[1] = SRC_HS;
        end
    end

    // one glitch-free switch per domain
    for (genvar c = 0; c < NCH; c++) begin : g_sw
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                sw_r[c] <= SW_RUN;
                cur_r[c] <= SRC_HS;
                tgt_r[c] <= SRC_HS;
                gate_r[c] <= 1'b0;
                out_r[c] <= 1'b0;
            end else begin
                out_r[c] <= gate_r[c] && run_r && clk_sync_r[cur_r[c]];
                unique case (sw_r[c])
                    SW_RUN: begin
                        gate_r[c] <= 1'b1;
                        if (want[c] != cur_r[c]) begin
                            tgt_r[c] <= want[c];
                            sw_r[c] <= SW_DRAIN_OLD;
                        end
                    end
                    SW_DRAIN_OLD: begin
                        if (!clk_sync_r[cur_r[c]]) begin
                            gate_r[c] <= 1'b0;
                            sw_r[c] <= SW_WAIT_NEW;
                        end
                    end
                    SW_WAIT_NEW: begin
                        if (!clk_sync_r[tgt_r[c]]) begin
                            cur_r[c] <= tgt_r[c];
                            sw_r[c] <= SW_RUN;
                        end
                    end
                    default: begin
                        sw_r[c] <= SW_RUN;
                    end
                endcase
            end
        end
    end

    // registered outputs: readback, status flags, oscillator controls
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            MAIN_CLOCK_MODE_Q <= MCM_RST;
            PROC_CLOCK_CTRL_Q <= PCC_RST;
            CLOCK_OP_MODE_Q <= OPM_RST;
            MAIN_OSC_CTRL_Q <= MOC_RST;
            INTERNAL_OSC_MODE_Q <= IOM_RST;
            CPU_ON_SUB_FLAG <= 1'b0;
            CPU_ON_MAIN_FLAG <= 1'b0;
            CPU_RUN <= 1'b0;
            CPU_CLK_OUT <= 1'b0;
            PERI_CLK_OUT <= 1'b0;
            HS_OSC_EN <= 1'b0;
            LS_OSC_EN <= 1'b0;
            MAIN_OSC_EN <= 1'b0;
            MAIN_XTAL_MODE <= 1'b0;
            SUB_OSC_EN <= 1'b0;
            SUB_XTAL_MODE <= 1'b0;
        end else begin
            MAIN_CLOCK_MODE_Q <= mcm_r;
            PROC_CLOCK_CTRL_Q <= pcc_r;
            CLOCK_OP_MODE_Q <= opm_r;
            MAIN_OSC_CTRL_Q <= moc_r;
            INTERNAL_OSC_MODE_Q <= iom_r;
            INTERNAL_OSC_MODE_Q[IOM_FAST_RUN_BIT] <= !iom_r[IOM_FAST_HALT_BIT];
            CPU_ON_SUB_FLAG <= cur_r[0] == SRC_SUB;
            CPU_ON_MAIN_FLAG <= cur_r[0] == SRC_X1 || cur_r[0] == SRC_EXT;
            CPU_RUN <= run_r;
            CPU_CLK_OUT <= out_r[0];
            PERI_CLK_OUT <= out_r[1];
            HS_OSC_EN <= !iom_r[IOM_FAST_HALT_BIT];
            LS_OSC_EN <= !iom_r[IOM_SLOW_HALT_BIT];
            MAIN_OSC_EN <= opm_r[OPM_MAIN_PIN_BIT] && !moc_r[MOC_HALT_BIT];
            MAIN_XTAL_MODE <= !opm_r[OPM_MAIN_EXT_BIT];
            SUB_OSC_EN <= pcc_r[PCC_XTAL_FORCE_BIT] || opm_r[OPM_SUB_PIN_BIT];
            SUB_XTAL_MODE <= pcc_r[PCC_XTAL_FORCE_BIT]
                || (!opm_r[OPM_SUB_EXT_BIT] && opm_r[OPM_SUB_PIN_BIT]);
        end
    end

    AST_DEFAULT_HS: assert property (
        @(posedge REF_CLK) disable iff (RST)
        $rose(run_r) && $past(sw_r[0]) == SW_RUN |-> cur_r[0] == SRC_HS)
        else $error("cpu not on fast oscillator at run start");

    AST_DUAL_DELAY: assert property (
        @(posedge REF_CLK) disable iff (RST)
        $rose(run_r) && dual_r |-> $past(cnt_r) == CNT_LAST)
        else $error("run started before reset processing time");

    AST_SRC_ONCE: assert property (
        @(posedge REF_CLK) disable iff (RST)
        $past(src_lock_r) |-> $stable(mcm_r[MCM_SRC_SEL_BIT]))
        else $error("source select changed twice");

    AST_RANGE_ONCE: assert property (
        @(posedge REF_CLK) disable iff (RST)
        $past(range_lock_r) |-> $stable(opm_r[OPM_RANGE_HI_BIT]))
        else $error("range bit changed twice");

    AST_SWITCH_TARGET: assert property (
        @(posedge REF_CLK) disable iff (RST)
        cur_r[0] != $past(cur_r[0]) |-> $past(sw_r[0]) == SW_WAIT_NEW
            && !$past(gate_r[0]) && cur_r[0] == $past(tgt_r[0]))
        else $error("cpu source changed outside a gated switch");

    AST_NO_RUNT: assert property (
        @(posedge REF_CLK) disable iff (RST)
        sw_r[1] == SW_WAIT_NEW |=> !out_r[1])
        else $error("peripheral clock pulsed during switch");

    AST_SUB_FLAG: assert property (
        @(posedge REF_CLK) disable iff (RST)
        sw_r[0] == SW_RUN && pcc_r[PCC_SUB_SEL_BIT]
            ##1 cur_r[0] == SRC_SUB |=> CPU_ON_SUB_FLAG && !CPU_ON_MAIN_FLAG)
        else $error("subsystem flag wrong");

    AST_CPU_MAIN: assert property (
        @(posedge REF_CLK) disable iff (RST)
        sw_r[0] == SW_RUN && !pcc_r[PCC_SUB_SEL_BIT]
            && mcm_r[MCM_SRC_SEL_BIT] && mcm_r[MCM_CPU_SEL_BIT]
            |-> want[0] == main_src(opm_r[OPM_MAIN_EXT_BIT]))
        else $error("cpu request not main clock");

    AST_FAST_HALT: assert property (
        @(posedge REF_CLK) disable iff (RST)
        INTERNAL_OSC_MODE_WR.we
            && INTERNAL_OSC_MODE_WR.data[IOM_FAST_HALT_BIT]
            && !MAIN_OSC_CTRL_WR.we |-> ##2 !HS_OSC_EN)
        else $error("fast oscillator not stopped");

    AST_SLOW_RESTART: assert property (
        @(posedge REF_CLK) disable iff (RST)
        INTERNAL_OSC_MODE_WR.we
            && !INTERNAL_OSC_MODE_WR.data[IOM_SLOW_HALT_BIT] |-> ##2 LS_OSC_EN)
        else $error("slow oscillator not restarted");

endmodule
`default_nettype wire

// ===== verification/cpu_peripheral_clock_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_peripheral_clock_select_tb;
    import clk_sel_pkg::*;
    localparam int POR_N = 8;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic dual = 1'b0;
    logic supply = 1'b0;
    logic hs = 1'b0, x1 = 1'b0, ext = 1'b0, sub = 1'b0;
    reg_wr_type wr_port [5] = '{default: '0};
    logic [REG_W-1:0] mcm_q, pcc_q, opm_q, moc_q, iom_q;
    logic cpu_sub, cpu_main, cpu_run, cpu_clk, peri_clk;
    logic hs_en, ls_en, main_en, main_xtal, sub_en, sub_xtal;
    int err_total = 0;
    int comparisons = 0;

    // reference clock and slow source clocks, all edges on falling edges
    always #25 ref_clk = ~ref_clk;
    always #200 hs = ~hs;
    always #250 x1 = ~x1;
    always #300 ext = ~ext;
    always #350 sub = ~sub;

    cpu_peripheral_clock_select #(.POR_CYCLES(POR_N)) DUT (
        .REF_CLK(ref_clk), .RST(rst), .POR_DUAL_MODE(dual),
        .SUPPLY_ABOVE_HI(supply), .HS_OSC_CLK(hs), .X1_CLK(x1),
        .EXT_MAIN_CLK(ext), .SUB_CLK(sub),
        .MAIN_CLOCK_MODE_WR(wr_port[0]), .PROC_CLOCK_CTRL_WR(wr_port[1]),
        .CLOCK_OP_MODE_WR(wr_port[2]), .MAIN_OSC_CTRL_WR(wr_port[3]),
        .INTERNAL_OSC_MODE_WR(wr_port[4]),
        .MAIN_CLOCK_MODE_Q(mcm_q), .PROC_CLOCK_CTRL_Q(pcc_q),
        .CLOCK_OP_MODE_Q(opm_q), .MAIN_OSC_CTRL_Q(moc_q),
        .INTERNAL_OSC_MODE_Q(iom_q), .CPU_ON_SUB_FLAG(cpu_sub),
        .CPU_ON_MAIN_FLAG(cpu_main), .CPU_RUN(cpu_run),
        .CPU_CLK_OUT(cpu_clk), .PERI_CLK_OUT(peri_clk), .HS_OSC_EN(hs_en),
        .LS_OSC_EN(ls_en), .MAIN_OSC_EN(main_en), .MAIN_XTAL_MODE(main_xtal),
        .SUB_OSC_EN(sub_en), .SUB_XTAL_MODE(sub_xtal)
    );

    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one-cycle write strobe, then wait until readback has landed
    task automatic wr(input int idx, input logic [7:0] d);
        @(negedge ref_clk);
        wr_port[idx] = '{we: 1'b1, data: d};
        @(negedge ref_clk);
        wr_port[idx].we = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    // cycles between two rising edges of a clock output
    task automatic period(input bit cpu, output int per);
        int n;
        n = 0;
        for (int k = 0; k < 4; k++) begin
            while ((cpu ? cpu_clk : peri_clk) !== k[0] && n < 200) begin
                @(negedge ref_clk);
                n++;
            end
            if (k == 1) n = 0;
        end
        per = n;
    endtask

    // let the switch settle, then check both clock periods, the sub flag and, if chk_m, the main flag
    task automatic clk_case(input int cp, input int pp, input logic sf,
                            input logic mf, input bit chk_m);
        int p;
        repeat (80) @(negedge ref_clk);
        period(1'b1, p);
        check(p[7:0], cp[7:0]);
        period(1'b0, p);
        check(p[7:0], pp[7:0]);
        check({7'h0, cpu_sub}, {7'h0, sf});
        if (chk_m) check({7'h0, cpu_main}, {7'h0, mf});
    endtask

    task automatic do_reset(input logic mode);
        @(negedge ref_clk);
        rst = 1'b1;
        dual = mode;
        supply = 1'b0;
        repeat (10) @(negedge ref_clk);
        check(moc_q, MOC_RST);
        check({7'h0, cpu_run}, 8'h00);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    // register defaults and default clocking after reset
    task automatic t_defaults();
        check(mcm_q, 8'h00);
        check(pcc_q, 8'h00);
        check(opm_q, 8'h00);
        check(moc_q, 8'h80);
        check(iom_q, 8'h80);
        check({7'h0, cpu_run}, 8'h01);
        check({6'h0, hs_en, ls_en}, 8'h03);
        check({7'h0, main_en}, 8'h00);
        clk_case(8, 8, 1'b0, 1'b0, 1'b1);
    endtask

    // source selection combinations in a legal order, all but cpu on subsystem with peripherals on X1
    task automatic t_select();
        wr(0, 8'h01);
        clk_case(8, 8, 1'b0, 1'b0, 1'b1);
        wr(2, 8'h30);
        wr(1, 8'h10);
        clk_case(14, 8, 1'b1, 1'b0, 1'b0);
        wr(1, 8'h00);
        wr(2, 8'hc0);
        wr(3, 8'h00);
        check({6'h0, main_en, main_xtal}, 8'h02);
        wr(0, 8'h04);
        clk_case(8, 12, 1'b0, 1'b0, 1'b1);
        wr(2, 8'h40);
        clk_case(8, 10, 1'b0, 1'b0, 1'b1);
        wr(0, 8'h05);
        clk_case(10, 10, 1'b0, 1'b1, 1'b1);
        wr(2, 8'hc0);
        clk_case(12, 12, 1'b0, 1'b1, 1'b1);
        wr(2, 8'hf0);
        wr(1, 8'h10);
        clk_case(14, 12, 1'b1, 1'b0, 1'b0);
        wr(0, 8'h01);
        check(mcm_q, 8'h05);
        clk_case(14, 12, 1'b1, 1'b0, 1'b0);
    endtask

    // bit positions, reserved bits, halts and write-once range bit
    task automatic t_regs();
        wr(4, 8'hff);
        check(iom_q, 8'h03);
        check({6'h0, hs_en, ls_en}, 8'h00);
        wr(4, 8'h01);
        check(iom_q, 8'h01);
        check({6'h0, hs_en, ls_en}, 8'h01);
        wr(3, 8'hff);
        check(moc_q, 8'h80);
        check({7'h0, main_en}, 8'h00);
        wr(2, 8'h71);
        check(opm_q, 8'h71);
        check({5'h0, main_xtal, sub_en, sub_xtal}, 8'h06);
        wr(2, 8'hb0);
        check(opm_q, 8'hb1);
        check({5'h0, main_xtal, sub_en, sub_xtal}, 8'h02);
        wr(2, 8'h10);
        check(opm_q, 8'h11);
        check({6'h0, sub_en, sub_xtal}, 8'h03);
        wr(2, 8'h00);
        wr(1, 8'h40);
        check({6'h0, sub_en, sub_xtal}, 8'h03);
        wr(1, 8'hff);
        check(pcc_q, 8'h50);
        wr(0, 8'hff);
        check(mcm_q, 8'h05);
    endtask

    // dual-threshold start: wait for supply, then the processing count
    task automatic t_por();
        int n;
        do_reset(1'b1);
        repeat (20) @(negedge ref_clk);
        check({7'h0, cpu_run}, 8'h00);
        supply = 1'b1;
        n = 0;
        while (cpu_run !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        check({7'h0, n >= POR_N && n <= POR_N + 5}, 8'h01);
        check(mcm_q, 8'h00);
        wr(0, 8'h04);
        check(mcm_q, 8'h04);
        clk_case(8, 10, 1'b0, 1'b0, 1'b1);
    endtask

    initial begin
        do_reset(1'b0);
        t_defaults();
        t_select();
        t_regs();
        t_por();
        end_of_test();
    end

    // hang guard
    initial begin
        #3000000;
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
